// file: hw/low_power_rtc_counter.sv
// Contract
// - 24-bit up-counter advanced from the low-frequency clock, value in count register low bits.
// - count rate is 32768 over prescale plus one; prescale in control bits 13..2.
// - control bit 0 runs or stops counting; zero after reset, so stopped.
// - writing one to control bit 1 zeroes the count; bit self-clears next clock.
// - event outputs gated: overflow bit 23, comparators 22..20, tick bit 19.
// - interrupt requests gated: overflow bit 18, comparators 17..15, tick bit 14.
// - a periodic tick event comes from the prescaled clock.
// - count register read returns live 24-bit count, upper eight bits zero.
// - writing the magic word to count register presets it just below overflow.
// - three separate read-write 24-bit compare registers, reset to zero.
// - read-only flag register: comparators at bits 0..2, overflow at bit 3.
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`include "rtc_params.svh"

module low_power_rtc_counter #(
  parameter int ADDR_W  = 16,
  parameter int NUM_CMP = 3,
  parameter int COUNT_W = 24
) (
  input  wire logic              clk_sys,        // system clock, 100 MHz
  input  wire logic              rst,            // synchronous reset, active high
  input  wire logic              low_freq_clock, // 32768 Hz clock level, sampled on clk_sys
  input  wire logic              psel,           // apb select
  input  wire logic              penable,        // apb access phase
  input  wire logic              pwrite,         // apb direction, high for write
  input  wire logic [ADDR_W-1:0] paddr,          // apb byte address
  input  wire logic [31:0]       pwdata,         // apb write data
  output logic      [31:0]       prdata,         // apb read data
  output logic                   pready,         // apb ready
  output logic                   pslverr,        // apb error, unmapped address
  output logic      [4:0]        event_out,      // gated event pulses
  output logic      [4:0]        irq_out         // gated interrupt request pulses
);

  initial begin
    if (ADDR_W < 16 || NUM_CMP != 3 || COUNT_W != 24) begin
      $error("low_power_rtc_counter: unsupported parameter values");
    end
  end

  localparam logic [ADDR_W-1:0] OFS_CTL  = ADDR_W'(`RTC_OFS_CONTROL);
  localparam logic [ADDR_W-1:0] OFS_CNT  = ADDR_W'(`RTC_OFS_COUNT);
  localparam logic [ADDR_W-1:0] OFS_CMP0 = ADDR_W'(`RTC_OFS_CMP0);
  localparam logic [ADDR_W-1:0] OFS_FLAG = ADDR_W'(`RTC_OFS_FLAGS);
  localparam logic [ADDR_W-1:0] STRIDE   = ADDR_W'(`RTC_CMP_STRIDE);

  // registers
  rtc_pkg::word_type     ctl_q;
  rtc_pkg::word_type     ctl_d;
  logic                  clear_q;
  logic                  clear_d;
  logic                  lf_q;
  rtc_pkg::presc_type    presc_q;
  rtc_pkg::presc_type    presc_d;
  rtc_pkg::count_type    count_q;
  rtc_pkg::count_type    count_d;
  rtc_pkg::flag_vec_type flags_q;
  rtc_pkg::flag_vec_type flags_d;
  rtc_pkg::flag_vec_type flag_snap_q;
  rtc_pkg::flag_vec_type flag_snap_d;
  rtc_pkg::word_type     prdata_q;
  rtc_pkg::word_type     prdata_d;
  logic                  err_q;
  logic                  err_d;
  rtc_pkg::src_vec_type  event_q;
  rtc_pkg::src_vec_type  irq_q;

  // bus decode
  logic                  setup_w;
  logic                  access_w;
  logic                  wr_w;
  logic                  rd_setup_w;
  logic                  rd_done_w;
  logic                  sel_ctl_w;
  logic                  sel_cnt_w;
  logic [NUM_CMP-1:0]    sel_cmp_w;
  logic                  sel_flag_w;
  logic                  hit_w;
  logic                  wr_ctl_w;
  logic                  wr_cnt_w;
  logic                  magic_w;
  rtc_pkg::word_type     ctl_rd_w;
  rtc_pkg::word_type     rd_mux_w;

  // counting path
  logic                  run_w;
  logic                  lf_rise_w;
  rtc_pkg::presc_type    presc_lim_w;
  logic                  presc_wrap_w;
  logic                  step_w;
  rtc_pkg::count_type    count_inc_w;
  logic                  ovf_w;
  logic [NUM_CMP-1:0]    match_w;
  rtc_pkg::src_vec_type  src_w;
  rtc_pkg::flag_vec_type flag_set_w;
  rtc_pkg::flag_vec_type flag_clr_w;
  logic                  presc_lock_w;

  rtc_cmp_if #(
    .NUM_CMP (NUM_CMP),
    .COUNT_W (COUNT_W)
  ) cmp_bus ();

  rtc_compare_bank #(
    .NUM_CMP (NUM_CMP),
    .COUNT_W (COUNT_W)
  ) u_compare_bank (
    .clk_sys (clk_sys),
    .rst     (rst),
    .cmp     (cmp_bus.bank)
  );

  // apb phases; zero wait states, read data is captured in setup
  assign setup_w    = psel & ~penable;
  assign access_w   = psel & penable;
  assign wr_w       = access_w & pwrite;
  assign rd_setup_w = setup_w & ~pwrite;
  assign rd_done_w  = access_w & ~pwrite;

  assign sel_ctl_w  = (paddr == OFS_CTL);
  assign sel_cnt_w  = (paddr == OFS_CNT);
  assign sel_flag_w = (paddr == OFS_FLAG);

  genvar i;
  generate
    for (i = 0; i < NUM_CMP; i++) begin : g_sel
      localparam logic [ADDR_W-1:0] OFS_I = ADDR_W'(OFS_CMP0 + ADDR_W'(i) * STRIDE);
      assign sel_cmp_w[i] = (paddr == OFS_I);
    end
  endgenerate

  assign hit_w    = sel_ctl_w | sel_cnt_w | (|sel_cmp_w) | sel_flag_w;
  assign wr_ctl_w = wr_w & sel_ctl_w;
  assign wr_cnt_w = wr_w & sel_cnt_w;
  // any other value written to the count register is dropped
  assign magic_w  = wr_cnt_w & (pwdata == `RTC_MAGIC_WORD);

  assign pready   = 1'b1;
  assign pslverr  = access_w & err_q;
  assign prdata   = prdata_q;

  // control: prescale frozen while running, clear bit kept apart
  assign run_w        = ctl_q[`RTC_CTL_RUN_BIT];
  assign presc_lock_w = run_w;

  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl_w) begin
      ctl_d = pwdata;
      ctl_d[`RTC_CTL_CLEAR_BIT] = 1'b0;
      if (presc_lock_w) begin
        ctl_d[`RTC_CTL_PRESC_MSB:`RTC_CTL_PRESC_LSB] = ctl_q[`RTC_CTL_PRESC_MSB:`RTC_CTL_PRESC_LSB];
      end
    end
  end

  assign clear_d = wr_ctl_w & pwdata[`RTC_CTL_CLEAR_BIT];

  always_comb begin
    ctl_rd_w = ctl_q;
    ctl_rd_w[`RTC_CTL_CLEAR_BIT] = clear_q;
  end

  // read selection
  assign rd_mux_w = sel_ctl_w    ? ctl_rd_w :
                    sel_cnt_w    ? {8'h00, count_q} :
                    sel_cmp_w[0] ? {8'h00, cmp_bus.value[0]} :
                    sel_cmp_w[1] ? {8'h00, cmp_bus.value[1]} :
                    sel_cmp_w[2] ? {8'h00, cmp_bus.value[2]} :
                    sel_flag_w   ? {28'h0000000, flags_q} :
                    32'h00000000;

  assign prdata_d = rd_setup_w ? rd_mux_w : prdata_q;
  assign err_d    = setup_w ? ~hit_w : err_q;

  // only flags actually reported to software are cleared by the read
  assign flag_snap_d = (rd_setup_w & sel_flag_w) ? flags_q :
                       setup_w                   ? 4'h0 :
                       flag_snap_q;
  assign flag_clr_w  = rd_done_w ? flag_snap_q : 4'h0;

  // prescaler: one step every prescale+1 rising edges of the slow clock
  assign lf_rise_w    = low_freq_clock & ~lf_q;
  assign presc_lim_w  = ctl_q[`RTC_CTL_PRESC_MSB:`RTC_CTL_PRESC_LSB];
  assign presc_wrap_w = (presc_q == presc_lim_w);
  assign step_w       = run_w & lf_rise_w & presc_wrap_w & ~clear_q & ~magic_w;

  always_comb begin
    presc_d = presc_q;
    if (clear_q) begin
      presc_d = 12'h000;
    end else if (run_w & lf_rise_w) begin
      presc_d = presc_wrap_w ? 12'h000 : presc_q + 12'h001;
    end
  end

  // counter: clear beats preset beats step
  assign count_inc_w = count_q + 24'h000001;
  assign ovf_w       = step_w & (&count_q);

  always_comb begin
    count_d = count_q;
    if (clear_q) begin
      count_d = `RTC_COUNT_RESET;
    end else if (magic_w) begin
      count_d = `RTC_PRESET_VALUE;
    end else if (step_w) begin
      count_d = count_inc_w;
    end
  end

  // comparators see the value the counter is stepping to
  assign cmp_bus.wr_en      = sel_cmp_w & {NUM_CMP{wr_w}};
  assign cmp_bus.wdata      = pwdata[COUNT_W-1:0];
  assign cmp_bus.step       = step_w;
  assign cmp_bus.count_next = count_inc_w;
  assign match_w            = cmp_bus.match;

  // sources: tick on every counter step
  assign src_w = {ovf_w, match_w, step_w};

  // set wins over the read clear
  assign flag_set_w = {ovf_w, match_w};
  assign flags_d    = (flags_q & ~flag_clr_w) | flag_set_w;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctl_q   <= `RTC_CTL_RESET;
      clear_q <= 1'b0;
    end else begin
      ctl_q   <= ctl_d;
      clear_q <= clear_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lf_q    <= 1'b0;
      presc_q <= 12'h000;
      count_q <= `RTC_COUNT_RESET;
    end else begin
      lf_q    <= low_freq_clock;
      presc_q <= presc_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_q     <= `RTC_FLAGS_RESET;
      flag_snap_q <= 4'h0;
    end else begin
      flags_q     <= flags_d;
      flag_snap_q <= flag_snap_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
      err_q    <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      err_q    <= err_d;
    end
  end

  // gated outputs, one cycle after the source
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      event_q <= 5'h00;
      irq_q   <= 5'h00;
    end else begin
      event_q <= src_w & ctl_q[`RTC_CTL_EVT_EN_MSB:`RTC_CTL_EVT_EN_LSB];
      irq_q   <= src_w & ctl_q[`RTC_CTL_IRQ_EN_MSB:`RTC_CTL_IRQ_EN_LSB];
    end
  end

  assign event_out = event_q;
  assign irq_out   = irq_q;

endmodule : low_power_rtc_counter

// file: common/rtc_params.svh
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// register byte addresses
`define RTC_OFS_CONTROL      16'hf024
`define RTC_OFS_COUNT        16'hf028
`define RTC_OFS_CMP0         16'hf02c
`define RTC_OFS_CMP1         16'hf030
`define RTC_OFS_CMP2         16'hf034
`define RTC_OFS_FLAGS        16'hf038
`define RTC_CMP_STRIDE       16'h0004

// control field positions
`define RTC_CTL_RUN_BIT      0
`define RTC_CTL_CLEAR_BIT    1
`define RTC_CTL_PRESC_LSB    2
`define RTC_CTL_PRESC_MSB    13
`define RTC_CTL_IRQ_EN_LSB   14
`define RTC_CTL_IRQ_EN_MSB   18
`define RTC_CTL_EVT_EN_LSB   19
`define RTC_CTL_EVT_EN_MSB   23

// source vector positions, shared by event and interrupt enables
`define RTC_SRC_TICK         0
`define RTC_SRC_CMP_LSB      1
`define RTC_SRC_CMP_MSB      3
`define RTC_SRC_OVF          4
`define RTC_NUM_SRC          5

// result flag positions
`define RTC_FLAG_CMP_LSB     0
`define RTC_FLAG_CMP_MSB     2
`define RTC_FLAG_OVF_BIT     3
`define RTC_NUM_FLAGS        4

// reset and special values
`define RTC_CTL_RESET        32'h00000000
`define RTC_COUNT_RESET      24'h000000
`define RTC_CMP_RESET        24'h000000
`define RTC_FLAGS_RESET      4'h0
`define RTC_MAGIC_WORD       32'h05a5a5a5
`define RTC_PRESET_VALUE     24'hfffff0

`endif

// file: common/rtc_pkg.sv
package rtc_pkg;

  typedef logic [23:0] count_type;
  typedef logic [11:0] presc_type;
  typedef logic [4:0]  src_vec_type;
  typedef logic [3:0]  flag_vec_type;
  typedef logic [31:0] word_type;

endpackage : rtc_pkg

// file: common/rtc_cmp_if.sv
`timescale 1ns/10ps

interface rtc_cmp_if #(
  parameter int NUM_CMP = 3,
  parameter int COUNT_W = 24
);
  logic [NUM_CMP-1:0] wr_en;
  logic [COUNT_W-1:0] wdata;
  logic               step;
  logic [COUNT_W-1:0] count_next;
  logic [COUNT_W-1:0] value [NUM_CMP];
  logic [NUM_CMP-1:0] match;

  modport core (output wr_en, output wdata, output step, output count_next,
                input value, input match);
  modport bank (input wr_en, input wdata, input step, input count_next,
                output value, output match);
endinterface : rtc_cmp_if

// file: hw/rtc_compare_bank.sv
`timescale 1ns/10ps
`include "rtc_params.svh"

module rtc_compare_bank #(
  parameter int NUM_CMP = 3,
  parameter int COUNT_W = 24
) (
  input  wire logic clk_sys, // system clock
  input  wire logic rst,     // synchronous reset, active high
  rtc_cmp_if.bank   cmp      // compare registers and match strobes
);

  initial begin
    if (NUM_CMP < 1 || COUNT_W != 24) begin
      $error("rtc_compare_bank: unsupported NUM_CMP or COUNT_W");
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_CMP; i++) begin : g_cmp
      logic [COUNT_W-1:0] value_q;

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          value_q <= `RTC_CMP_RESET;
        end else if (cmp.wr_en[i]) begin
          value_q <= cmp.wdata;
        end
      end

      assign cmp.value[i] = value_q;
      // match only on a real step, so a write equal to the count stays quiet
      assign cmp.match[i] = cmp.step & (cmp.count_next == value_q);
    end
  endgenerate

endmodule : rtc_compare_bank

// file: dv/low_power_rtc_counter_assertions.sv
`timescale 1ns/10ps
`include "rtc_params.svh"

module low_power_rtc_counter_assertions #(
  parameter int ADDR_W = 16
) (
  input wire logic              clk_sys,        // clock
  input wire logic              rst,            // sync reset
  input wire logic              low_freq_clock, // lf level
  input wire logic              psel,           // apb select
  input wire logic              penable,        // apb access
  input wire logic              pwrite,         // apb write
  input wire logic [ADDR_W-1:0] paddr,          // apb address
  input wire logic [31:0]       pwdata,         // apb wdata
  input wire logic [31:0]       prdata,         // apb rdata
  input wire logic              pready,         // apb ready
  input wire logic              pslverr,        // apb error
  input wire logic [4:0]        event_out,      // events
  input wire logic [4:0]        irq_out         // irqs
);
  logic [31:0] ctl_q;
  wire         acc    = psel && penable && pready;
  wire         rd_acc = acc && !pwrite;
  wire         wr_ctl = acc && pwrite && paddr == `RTC_OFS_CONTROL;
  wire  [4:0]  ev_en  = ctl_q[23:19];
  wire  [4:0]  ir_en  = ctl_q[18:14];
  wire         mapped = paddr inside {`RTC_OFS_CONTROL, `RTC_OFS_COUNT, `RTC_OFS_CMP0,
                                      `RTC_OFS_CMP1, `RTC_OFS_CMP2, `RTC_OFS_FLAGS};

  // shadow of the control word, only the gating bits and run bit 0 matter here
  always_ff @(posedge clk_sys) begin
    if (rst) ctl_q <= 32'h00000000;
    else if (wr_ctl) ctl_q <= pwdata;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_evt_gate: assert property ((event_out & ~ev_en & ~$past(ev_en)) == 5'h00)
    else $error("event pulse while disabled");
  chk_irq_gate: assert property ((irq_out & ~ir_en & ~$past(ir_en)) == 5'h00)
    else $error("irq pulse while disabled");
  chk_evt_irq_pair: assert property (($stable(ev_en) && $stable(ir_en)) |->
    ((event_out & ev_en & ir_en) == (irq_out & ev_en & ir_en)))
    else $error("event and irq disagree");
  chk_stop_no_tick: assert property ((!$past(ctl_q[0]) && !$past(ctl_q[0], 2)) |->
    (!event_out[0] && !irq_out[0]))
    else $error("tick while stopped");
  chk_pulse_single: assert property (((event_out & $past(event_out)) | (irq_out & $past(irq_out))) == 5'h00)
    else $error("pulse longer than one cycle");
  chk_err_unmapped: assert property (pslverr |-> (psel && penable && !mapped))
    else $error("error outside unmapped access");
  chk_count_upper: assert property ((rd_acc && paddr == `RTC_OFS_COUNT) |-> prdata[31:24] == 8'h00)
    else $error("count upper bits not zero");
  chk_flag_upper: assert property ((rd_acc && paddr == `RTC_OFS_FLAGS) |-> prdata[31:4] == 28'h0000000)
    else $error("flag upper bits not zero");
  // a tick pulse trails the slow clock rise that stepped the counter by one edge
  chk_tick_lf_rise: assert property ((event_out[0] || irq_out[0]) |->
    ($past(low_freq_clock) && !$past(low_freq_clock, 2)))
    else $error("tick without a slow clock rise");

  cov_tick: cover property (event_out[0]);
  cov_ovf_irq: cover property (irq_out[4]);
  cov_cmp_evt: cover property (|event_out[3:1]);
endmodule : low_power_rtc_counter_assertions

bind low_power_rtc_counter low_power_rtc_counter_assertions #(.ADDR_W(ADDR_W)) chk_u (
  .clk_sys(clk_sys), .rst(rst), .low_freq_clock(low_freq_clock), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .event_out(event_out), .irq_out(irq_out));

// file: dv/low_power_rtc_counter_tb_top.sv
`timescale 1ns/10ps
`include "rtc_params.svh"

module low_power_rtc_counter_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        lf      = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [15:0] paddr   = 16'h0000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  event_out;
  logic [4:0]  irq_out;
  logic [31:0] rd;
  logic        er;
  int          err_count;
  int          samples_checked;
  int          ev_n[5];
  int          ir_n[5];

  always #5 clk_sys = ~clk_sys;

  low_power_rtc_counter #(.ADDR_W(16)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .low_freq_clock(lf), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_out(event_out), .irq_out(irq_out));

  always @(posedge clk_sys) begin
    for (int i = 0; i < 5; i++) begin
      ev_n[i] <= ev_n[i] + int'(event_out[i]);
      ir_n[i] <= ir_n[i] + int'(irq_out[i]);
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // entered and left just after a rising edge, one idle cycle at the end
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin err_count++; print_verdict(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask : rchk

  // lf period of six system cycles, stands low between bursts
  task automatic lf_edges(input int n);
    repeat (n) begin
      lf <= 1'b1; repeat (3) @(posedge clk_sys);
      lf <= 1'b0; repeat (3) @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
  endtask : lf_edges

  task automatic sc_reset();
    logic [15:0] a[6] = '{`RTC_OFS_CONTROL, `RTC_OFS_COUNT, `RTC_OFS_CMP0, `RTC_OFS_CMP1, `RTC_OFS_CMP2, `RTC_OFS_FLAGS};
    foreach (a[i]) begin
      rchk(a[i], 32'h00000000);
      chk({31'h0, er}, 32'h00000000);
    end
    apb(1'b1, 16'hf03c, 32'hffffffff);
    chk({31'h0, er}, 32'h00000001);
  endtask : sc_reset

  task automatic sc_regs();
    for (int i = 0; i < 3; i++) apb(1'b1, `RTC_OFS_CMP0 + 16'(4 * i), 32'hffa5a5a5 ^ 32'(i));
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, `RTC_OFS_CMP0 + 16'(4 * i), 32'h00000000);
      chk(rd, 32'h00a5a5a5 ^ 32'(i));
    end
    apb(1'b1, `RTC_OFS_FLAGS, 32'hffffffff);
    rchk(`RTC_OFS_FLAGS, 32'h00000000);
    apb(1'b1, `RTC_OFS_CONTROL, 32'habfffffc);
    rchk(`RTC_OFS_CONTROL, 32'habfffffc);
    apb(1'b1, `RTC_OFS_CONTROL, 32'h00000000);
  endtask : sc_regs

  task automatic sc_count();
    apb(1'b1, `RTC_OFS_CONTROL, 32'h00000002);
    apb(1'b1, `RTC_OFS_CONTROL, 32'h00000001);
    lf_edges(5);
    rchk(`RTC_OFS_COUNT, 32'h00000005);
    apb(1'b1, `RTC_OFS_CONTROL, 32'h00000000);
    lf_edges(2);
    rchk(`RTC_OFS_COUNT, 32'h00000005);
    apb(1'b1, `RTC_OFS_CONTROL, 32'h0000000a);
    rchk(`RTC_OFS_COUNT, 32'h00000000);
    rchk(`RTC_OFS_CONTROL, 32'h00000008);
    apb(1'b1, `RTC_OFS_CONTROL, 32'h00000009);
    lf_edges(9);
    rchk(`RTC_OFS_COUNT, 32'h00000003);
  endtask : sc_count

  // pulse counts are judged as differences, the counters have one driver
  task automatic sc_ovf();
    int ev0[5];
    int ir0[5];
    apb(1'b1, `RTC_OFS_CONTROL, 32'h00000002);
    apb(1'b1, `RTC_OFS_COUNT, `RTC_MAGIC_WORD);
    rchk(`RTC_OFS_COUNT, 32'h00fffff0);
    apb(1'b1, `RTC_OFS_COUNT, 32'h00000007);
    rchk(`RTC_OFS_COUNT, 32'h00fffff0);
    ev0 = ev_n;
    ir0 = ir_n;
    apb(1'b1, `RTC_OFS_CONTROL, 32'h008c0001);
    lf_edges(16);
    rchk(`RTC_OFS_COUNT, 32'h00000000);
    chk(ev_n[4] - ev0[4], 32'h1);
    chk(ir_n[4] - ir0[4], 32'h1);
    chk(ev_n[0] - ev0[0], 32'h10);
    chk(ir_n[0] - ir0[0], 32'h0);
    rchk(`RTC_OFS_FLAGS, 32'h00000008);
  endtask : sc_ovf

  task automatic sc_cmp();
    int ev0[5];
    int ir0[5];
    apb(1'b1, `RTC_OFS_CONTROL, 32'h00000002);
    apb(1'b1, `RTC_OFS_CMP0, 32'h00000003);
    apb(1'b1, `RTC_OFS_CMP1, 32'h00000005);
    apb(1'b1, `RTC_OFS_CMP2, 32'h00000005);
    apb(1'b1, `RTC_OFS_CONTROL, 32'h00510004);
    ev0 = ev_n;
    ir0 = ir_n;
    apb(1'b1, `RTC_OFS_CONTROL, 32'h00510005);
    lf_edges(12);
    rchk(`RTC_OFS_COUNT, 32'h00000006);
    chk(ev_n[3] - ev0[3], 32'h1);
    chk(ev_n[2] - ev0[2], 32'h0);
    chk(ev_n[1] - ev0[1], 32'h1);
    chk(ev_n[0] - ev0[0], 32'h0);
    chk(ir_n[3] - ir0[3], 32'h0);
    chk(ir_n[2] - ir0[2], 32'h1);
    chk(ir_n[1] - ir0[1], 32'h0);
    rchk(`RTC_OFS_FLAGS, 32'h00000007);
    rchk(`RTC_OFS_FLAGS, 32'h00000000);
  endtask : sc_cmp

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    sc_reset();
    sc_regs();
    sc_count();
    sc_ovf();
    sc_cmp();
    print_verdict();
  end
endmodule : low_power_rtc_counter_tb_top
